/* File: ddsa_router.sv */
// dual data space access router: steers core accesses to x and y storage
`timescale 1ns/1ns
`default_nettype none
`include "ddsa_consts.svh"
module ddsa_router #(
  parameter bit REDUCED = 1'b0,
  parameter int WORDS = `DDSA_WORDS_PER_SPACE
) (
  input wire logic clk_sys, // core clock
  input wire logic rst_b, // synchronous reset, active low
  input wire ddsa_pkg::ddsa_ctl_s ctl, // access control from core
  input wire ddsa_pkg::ddsa_agu_req_s x_req, // x generator request
  input wire ddsa_pkg::ddsa_agu_req_s y_req, // y generator request
  output ddsa_pkg::ddsa_data_t x_rd_data, // x read bus
  output logic x_rd_valid, // x read data valid
  output ddsa_pkg::ddsa_data_t y_rd_data, // y read bus
  output logic y_rd_valid, // y read data valid
  output logic wr_to_y // last write landed in y storage
);
  import ddsa_pkg::*;
  localparam int IW = $clog2(WORDS);
  ddsa_data_t x_mem [WORDS];
  ddsa_data_t y_mem [WORDS];
  ddsa_addr_t x_ea;
  ddsa_addr_t y_ea;
  logic x_rd_in_y;
  logic wr_in_y;
  logic y_rd_en;
  logic [IW-1:0] x_rd_idx;
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] y_idx;
  logic wr_x_en;
  logic wr_y_en;
  ddsa_data_t x_rd_data_d;
  ddsa_data_t x_rd_data_q;
  ddsa_data_t y_rd_data_d;
  ddsa_data_t y_rd_data_q;
  logic x_rd_valid_d;
  logic x_rd_valid_q;
  logic y_rd_valid_d;
  logic y_rd_valid_q;
  logic wr_to_y_d;
  logic wr_to_y_q;

  ddsa_address_generator #(.HAS_MODULO(!REDUCED), .HAS_BITREV(!REDUCED)) u_x_gen (
    .req(x_req),
    .is_write(ctl.wr_valid),
    .ea(x_ea)
  );
  // y generator never sees a write, so bit-reversal cannot act on it
  ddsa_address_generator #(.HAS_MODULO(!REDUCED), .HAS_BITREV(1'b0)) u_y_gen (
    .req(y_req),
    .is_write(1'b0),
    .ea(y_ea)
  );

  // address decode against the fixed boundary
  always_comb begin
    // word address: bit 0 selects a byte and is dropped
    x_rd_in_y = (x_ea >= `DDSA_XY_BOUNDARY);
    wr_in_y = (x_ea >= `DDSA_XY_BOUNDARY);
    y_rd_en = ctl.rd_valid && ctl.mac_class && y_req.valid;
    x_rd_idx = x_rd_in_y ? IW'((x_ea - `DDSA_XY_BOUNDARY) >> 1) : IW'(x_ea >> 1);
    wr_idx = x_rd_idx;
    y_idx = IW'((y_ea - `DDSA_XY_BOUNDARY) >> 1);
    wr_x_en = ctl.wr_valid && x_req.valid && !wr_in_y;
    wr_y_en = ctl.wr_valid && x_req.valid && wr_in_y;
  end

  // read path: data holds until the next read of the same bus
  always_comb begin
    x_rd_valid_d = ctl.rd_valid && x_req.valid;
    x_rd_data_d = x_rd_data_q;
    if (x_rd_valid_d) begin
      x_rd_data_d = x_rd_in_y ? y_mem[x_rd_idx] : x_mem[x_rd_idx];
    end
    y_rd_valid_d = y_rd_en;
    y_rd_data_d = y_rd_data_q;
    if (y_rd_en) begin
      y_rd_data_d = y_mem[y_idx];
    end
  end

  // write status: remembers which space took the last write
  always_comb begin
    wr_to_y_d = wr_to_y_q;
    if (wr_x_en || wr_y_en) begin
      wr_to_y_d = wr_y_en;
    end
  end

  // output registers

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      x_rd_data_q <= '0;
      x_rd_valid_q <= 1'b0;
      y_rd_data_q <= '0;
      y_rd_valid_q <= 1'b0;
      wr_to_y_q <= 1'b0;
    end else begin
      x_rd_data_q <= x_rd_data_d;
      x_rd_valid_q <= x_rd_valid_d;
      y_rd_data_q <= y_rd_data_d;
      y_rd_valid_q <= y_rd_valid_d;
      wr_to_y_q <= wr_to_y_d;
    end
  end

  // storage: separate write path so a read and write may share a cycle
  always_ff @(posedge clk_sys) begin
    // a read in the same cycle still sees the old word
    if (wr_y_en) begin
      y_mem[wr_idx] <= ctl.wr_data;
    end else if (wr_x_en) begin
      x_mem[wr_idx] <= ctl.wr_data;
    end
  end

  assign x_rd_data = x_rd_data_q;
  assign x_rd_valid = x_rd_valid_q;
  assign y_rd_data = y_rd_data_q;
  assign y_rd_valid = y_rd_valid_q;
  assign wr_to_y = wr_to_y_q;

  x_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctl.rd_valid && x_req.valid) |=> x_rd_valid)
    else $error("x read not answered next cycle");

  y_only_mac_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctl.rd_valid && !ctl.mac_class) |=> !y_rd_valid)
    else $error("y read without multiply-accumulate class");

  y_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctl.rd_valid && ctl.mac_class && y_req.valid) |=> y_rd_valid)
    else $error("y read not answered");

  wr_steer_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctl.wr_valid && x_req.valid) |=> (wr_to_y == ($past(x_ea) >= `DDSA_XY_BOUNDARY)))
    else $error("write steered to wrong space");

  boundary_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    x_rd_in_y == (x_ea >= `DDSA_XY_BOUNDARY))
    else $error("boundary moved");

  y_bitrev_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (y_req.mode == DDSA_MODE_BITREV) |-> (y_ea == y_req.base + y_req.offset))
    else $error("bit-reversal applied to y");

  reduced_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    REDUCED |-> (x_ea == x_req.base + x_req.offset))
    else $error("reduced variant altered address");

  x_data_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !$past(x_rd_valid_d) |-> $stable(x_rd_data))
    else $error("x read data changed without read");

  reset_clear_a: assert property (@(posedge clk_sys)
    !rst_b |=> (!x_rd_valid && !y_rd_valid && !wr_to_y))
    else $error("outputs not cleared by reset");

  x_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(ctl.rd_valid && x_req.valid) |=> !x_rd_valid)
    else $error("x read valid without request");

  y_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !y_rd_en |=> !y_rd_valid)
    else $error("y read valid without request");

  y_data_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !$past(y_rd_en) |-> $stable(y_rd_data))
    else $error("y read data changed without read");

  wr_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !$past(wr_x_en || wr_y_en) |-> $stable(wr_to_y))
    else $error("write status changed without write");

  rd_with_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctl.rd_valid && ctl.wr_valid && x_req.valid) |=> x_rd_valid)
    else $error("read lost beside a write");

  linear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (x_req.mode == DDSA_MODE_LINEAR) |-> (x_ea == x_req.base + x_req.offset))
    else $error("linear address altered");

  x_bitrev_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (x_req.mode == DDSA_MODE_BITREV && !ctl.wr_valid)
    |-> (x_ea == x_req.base + x_req.offset))
    else $error("bit-reversal applied to x read");

  x_mod_in_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (x_req.mode == DDSA_MODE_MODULO && (x_req.base + x_req.offset) >= x_req.mod_start
    && (x_req.base + x_req.offset) <= x_req.mod_end)
    |-> (x_ea == x_req.base + x_req.offset))
    else $error("x modulo moved an in-range address");

  x_mod_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!REDUCED && x_req.mode == DDSA_MODE_MODULO && (x_req.base + x_req.offset) > x_req.mod_end)
    |-> (x_ea == x_req.base + x_req.offset - (x_req.mod_end - x_req.mod_start + 16'h0001)))
    else $error("x modulo wrap wrong");

  y_mod_in_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (y_req.mode == DDSA_MODE_MODULO && (y_req.base + y_req.offset) >= y_req.mod_start
    && (y_req.base + y_req.offset) <= y_req.mod_end)
    |-> (y_ea == y_req.base + y_req.offset))
    else $error("y modulo moved an in-range address");

  y_mod_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!REDUCED && y_req.mode == DDSA_MODE_MODULO && (y_req.base + y_req.offset) > y_req.mod_end)
    |-> (y_ea == y_req.base + y_req.offset - (y_req.mod_end - y_req.mod_start + 16'h0001)))
    else $error("y modulo wrap wrong");

  wr_x_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_x_en |=> !wr_to_y)
    else $error("x write reported as y");
endmodule
`default_nettype wire

/* File: ddsa_consts.svh */
// constants for the dual data space access router
`ifndef DDSA_CONSTS_SVH
`define DDSA_CONSTS_SVH
`define DDSA_AW 16
`define DDSA_DW 16
`define DDSA_XY_BOUNDARY 16'h5000
`define DDSA_WORDS_PER_SPACE 2048
`endif

/* File: ddsa_pkg.sv */
// types for the dual data space access router
`include "ddsa_consts.svh"
package ddsa_pkg;
  typedef logic [`DDSA_AW-1:0] ddsa_addr_t;
  typedef logic [`DDSA_DW-1:0] ddsa_data_t;
  typedef enum logic [1:0] {
    DDSA_MODE_LINEAR = 2'b00,
    DDSA_MODE_MODULO = 2'b01,
    DDSA_MODE_BITREV = 2'b10
  } ddsa_mode_e;
  typedef struct packed {
    logic valid;
    ddsa_mode_e mode;
    ddsa_addr_t base;
    ddsa_addr_t offset;
    ddsa_addr_t mod_start;
    ddsa_addr_t mod_end;
    ddsa_addr_t bitrev_size;
  } ddsa_agu_req_s;
  typedef struct packed {
    logic rd_valid;
    logic wr_valid;
    logic mac_class;
    ddsa_data_t wr_data;
  } ddsa_ctl_s;
endpackage

/* File: ddsa_address_generator.sv */
// one address generator: linear, modulo and bit-reversed effective addresses
`timescale 1ns/1ns
`default_nettype none
`include "ddsa_consts.svh"
module ddsa_address_generator #(
  parameter bit HAS_MODULO = 1'b1,
  parameter bit HAS_BITREV = 1'b1
) (
  input wire ddsa_pkg::ddsa_agu_req_s req, // address request
  input wire logic is_write, // access is a write
  output logic [`DDSA_AW-1:0] ea // effective address
);
  import ddsa_pkg::*;
  ddsa_addr_t sum;
  ddsa_addr_t span;
  ddsa_addr_t rev;
  always_comb begin
    sum = req.base + req.offset;
    span = req.mod_end - req.mod_start + 16'h0001;
    for (int i = 0; i < `DDSA_AW; i++) begin
      rev[i] = req.offset[`DDSA_AW-1-i];
    end
    ea = sum;
    if (HAS_MODULO && req.mode == DDSA_MODE_MODULO) begin
      if (sum > req.mod_end) begin
        ea = sum - span;
      end else if (sum < req.mod_start) begin
        ea = sum + span;
      end
    end else if (HAS_BITREV && is_write && req.mode == DDSA_MODE_BITREV) begin
      // reverse the low four offset bits, bit 0 included, masked to the buffer size
      ea = req.base + ((rev >> (`DDSA_AW - $clog2(`DDSA_AW))) & (req.bitrev_size - 16'h0001));
      ea = req.base ^ (req.offset & ~(req.bitrev_size - 16'h0001)) ^ ea ^ req.base;
    end
  end
endmodule
`default_nettype wire

/* File: ddsa_core_model.sv */
// core-side request model for the dual data space router
`timescale 1ns/1ns
`default_nettype none
module ddsa_core_model (
  input wire logic clk_sys, // core clock
  output var ddsa_pkg::ddsa_ctl_s ctl, // access control
  output var ddsa_pkg::ddsa_agu_req_s x_req, // x generator request
  output var ddsa_pkg::ddsa_agu_req_s y_req // y generator request
);
  import ddsa_pkg::*;
  initial begin
    ctl = '0;
    x_req = '0;
    y_req = '0;
  end
  // one request per call, held only for its taking edge
  task automatic issue_mode(input logic rd, wr, mac, input ddsa_mode_e m,
    input ddsa_addr_t xa, xo, ya, yo, ms, me, input ddsa_data_t d);
    @(posedge clk_sys);
    ctl <= '{rd, wr, mac, d};
    x_req <= '{1'b1, m, xa, xo, ms, me, 16'h0010};
    y_req <= '{1'b1, m, ya, yo, ms, me, 16'h0010};
    @(posedge clk_sys);
    // released data wire shows the inverse so stale data cannot pass
    ctl <= '{1'b0, 1'b0, 1'b0, ~d};
    x_req.valid <= 1'b0;
    y_req.valid <= 1'b0;
  endtask
  task automatic issue(input logic rd, wr, mac, input ddsa_addr_t xa, ya, input ddsa_data_t d);
    issue_mode(rd, wr, mac, DDSA_MODE_LINEAR, xa, 16'h0000, ya, 16'h0000, 16'h0000, 16'h0000, d);
  endtask
endmodule
`default_nettype wire

/* File: test_ddsa_router.sv */
// self-checking bench for the dual data space router
`timescale 1ns/1ns
`default_nettype none
module test_ddsa_router;
  import ddsa_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  ddsa_ctl_s ctl;
  ddsa_agu_req_s x_req, y_req;
  ddsa_data_t x_rd_data, y_rd_data, d1, d2, d3;
  logic x_rd_valid, y_rd_valid, wr_to_y;
  int fails = 0;
  int cmp_count = 0;
  int seed = 35;
  int cyc = 0;
  ddsa_data_t xq[$], yq[$];
  always #2 clk_sys = ~clk_sys;
  ddsa_core_model u_core (.clk_sys(clk_sys), .ctl(ctl), .x_req(x_req), .y_req(y_req));
  ddsa_router u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ctl(ctl), .x_req(x_req),
    .y_req(y_req), .x_rd_data(x_rd_data), .x_rd_valid(x_rd_valid), .y_rd_data(y_rd_data),
    .y_rd_valid(y_rd_valid), .wr_to_y(wr_to_y));
  task automatic check(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a valid with no note pending is itself a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 500) begin
      fails++;
      tally_and_finish;
    end else begin
      if (x_rd_valid === 1'b1) begin
        if (xq.size() == 0) check("x valid", 16'h0000, 16'h0001);
        else check("x data", xq.pop_front(), x_rd_data);
      end
      if (y_rd_valid === 1'b1) begin
        if (yq.size() == 0) check("y valid", 16'h0000, 16'h0001);
        else check("y data", yq.pop_front(), y_rd_data);
      end
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    d1 = 16'($random(seed));
    d2 = 16'($random(seed));
    d3 = 16'($random(seed));
    u_core.issue(1'b0, 1'b1, 1'b0, 16'h0100, 16'h0000, d1);
    @(negedge clk_sys);
    check("wr_to_y", 16'h0000, {15'h0000, wr_to_y});
    u_core.issue(1'b0, 1'b1, 1'b0, 16'h5002, 16'h0000, d2);
    @(negedge clk_sys);
    check("wr_to_y", 16'h0001, {15'h0000, wr_to_y});
    $display("test writes done");
    xq.push_back(d1);
    u_core.issue(1'b1, 1'b0, 1'b0, 16'h0100, 16'h5002, 16'h0000);
    xq.push_back(d2);
    u_core.issue(1'b1, 1'b0, 1'b0, 16'h5002, 16'h0000, 16'h0000);
    $display("test combined reads done");
    xq.push_back(d1);
    yq.push_back(d2);
    u_core.issue(1'b1, 1'b0, 1'b1, 16'h0100, 16'h5002, 16'h0000);
    $display("test dual read done");
    xq.push_back(d1);
    u_core.issue(1'b1, 1'b1, 1'b0, 16'h0100, 16'h0000, d3);
    xq.push_back(d3);
    u_core.issue(1'b1, 1'b0, 1'b0, 16'h0100, 16'h0000, 16'h0000);
    $display("test read with write done");
    xq.push_back(d2);
    yq.push_back(d2);
    u_core.issue_mode(1'b1, 1'b0, 1'b1, DDSA_MODE_MODULO, 16'h5000, 16'h0012, 16'h5000, 16'h0012,
      16'h5000, 16'h500F, 16'h0000);
    xq.push_back(d3);
    yq.push_back(d2);
    u_core.issue_mode(1'b1, 1'b0, 1'b1, DDSA_MODE_BITREV, 16'h0100, 16'h0000, 16'h5000, 16'h0002,
      16'h0000, 16'h0000, 16'h0000);
    u_core.issue_mode(1'b0, 1'b1, 1'b0, DDSA_MODE_BITREV, 16'h0300, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, d1);
    xq.push_back(d1);
    u_core.issue(1'b1, 1'b0, 1'b0, 16'h0300, 16'h0000, 16'h0000);
    repeat (3) @(posedge clk_sys);
    check("pending", 16'h0000, 16'(xq.size() + yq.size()));
    $display("test address modes done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
